// File: hw/rnp_pkg.sv
// ==================================================================
// Shared constants for the reset and interrupt pin control block
// ==================================================================
package rnp_pkg;

    // ==============================================================
    // Clock and pin timing
    // ==============================================================
    localparam int CLK_PERIOD_NS = 4;
    // Low pulses shorter than this must be ignored
    localparam int SPIKE_REJECT_NS = 10;
    // Low pulse that must always pass the filter
    localparam int SPIKE_PASS_NS = 100;
    // Least time rounds up to whole cycles
    localparam int SPIKE_REJECT_CYC = (SPIKE_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time rounds down to whole cycles
    localparam int SPIKE_PASS_CYC = SPIKE_PASS_NS / CLK_PERIOD_NS;
    // Filter width: accept once low for the reject time, far below the pass time
    localparam logic [4:0] FILT_LEN = 5'(SPIKE_REJECT_CYC);
    // Pin ignore time after releasing the drive: synchroniser plus filter plus margin
    localparam logic [4:0] HOLDOFF_LEN = 5'(SPIKE_REJECT_CYC + 4);
    // Default length of the internal reset sequence, in cycles
    localparam int RST_SEQ_CYC_DEF = 1024;
    localparam int SEQ_CNT_W = 16;

    // ==============================================================
    // Reset reason codes
    // ==============================================================
    localparam logic [1:0] RSRC_HW_LONG = 2'h0;
    localparam logic [1:0] RSRC_HW_SHORT = 2'h1;
    localparam logic [1:0] RSRC_SW = 2'h2;
    localparam logic [1:0] RSRC_WDOG = 2'h3;

    // ==============================================================
    // Sequencer states
    // ==============================================================
    typedef enum logic [1:0] {
        RNP_ST_SEQ = 2'b00,
        RNP_ST_INIT = 2'b01,
        RNP_ST_RUN = 2'b10
    } rnp_state_e;

endpackage : rnp_pkg

// File: hw/rnp_pin_if.sv
`timescale 1ns/1ps
// ==================================================================
// Conditioned pin levels and interrupt falling edge from the filter to the controller
// ==================================================================
interface rnp_pin_if;
    logic rst_low;
    logic nmi_level;
    logic nmi_fall;

    modport filt (output rst_low, output nmi_level, output nmi_fall);
    modport ctrl (input rst_low, input nmi_level, input nmi_fall);
endinterface : rnp_pin_if

// File: hw/rnp_pin_filter.sv
`timescale 1ns/1ps
// ==================================================================
// Pin synchronisers, spike filter and interrupt edge detector
// ==================================================================
module rnp_pin_filter (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic reset_pin_in,
    input wire logic nmi_pin_in,
    rnp_pin_if.filt pins
);

    localparam logic [4:0] FILT_LEN = rnp_pkg::FILT_LEN;

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic nmi_meta_ff;
    logic nmi_sync_ff;
    logic nmi_prev_ff;
    logic low_ff;
    logic [4:0] low_cnt_ff;
    logic [4:0] nxt_low_cnt;
    logic nxt_low;

    // ==============================================================
    // Two-stage synchronisers, idle high like the pulled-up pins
    // ==============================================================
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= 1'b1;
            nmi_meta_ff <= 1'b1;
            nmi_sync_ff <= 1'b1;
            nmi_prev_ff <= 1'b1;
        end else begin
            rst_meta_ff <= reset_pin_in;   // [R17]
            rst_sync_ff <= rst_meta_ff;    // [R17]
            nmi_meta_ff <= nmi_pin_in;     // [R17]
            nmi_sync_ff <= nmi_meta_ff;    // [R17]
            nmi_prev_ff <= nmi_sync_ff;
        end
    end

    // ==============================================================
    // Spike filter: low must stand for the full reject time
    // ==============================================================
    // Counting cycles rather than an analog RC keeps the limit exact;
    // any long pulse passes after only a few cycles of latency.
    assign nxt_low_cnt = rst_sync_ff ? 5'h00 :
                         (low_cnt_ff == FILT_LEN) ? low_cnt_ff : low_cnt_ff + 5'h01; // [R2]
    assign nxt_low = !rst_sync_ff && (nxt_low_cnt == FILT_LEN); // [R3]

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            low_cnt_ff <= 5'h00;
            low_ff <= 1'b0;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
            low_ff <= nxt_low;
        end
    end

    // Edge taken between two synchronised samples only
    assign pins.rst_low = low_ff;
    assign pins.nmi_level = nmi_sync_ff;
    assign pins.nmi_fall = nmi_prev_ff && !nmi_sync_ff; // [R10]

endmodule : rnp_pin_filter

// File: hw/rnp_reset_nmi_ctrl.sv
`timescale 1ns/1ps
// Function
// [R1] Low reset pin resets while oscillator runs
// [R2] Reset low pulses under 10 ns ignored
// [R3] Reset low pulses over 100 ns pass
// [R4] Source holds reset 100 ns plus two cycles
// [R5] Bidirectional mode drives pin low during sequence
// [R6] Bidirectional mode only when enable bit set
// [R7] Source should hold reset about 1 ms
// [R8] Indication low during any reset kind
// [R9] Indication stays low until end-of-init executes
// [R10] Interrupt pin falling edge raises trap
// [R11] Power-down with interrupt pin low enters
// [R12] Power-down with interrupt pin high ignored
// [R13] Unused interrupt pin tied high externally
// [R14] Enable locked after init, cleared by reset
// [R15] Bidirectional mode stretches short hardware reset
// [R16] Bidirectional mode reports long hardware reset
// [R17] Reset and interrupt pins synchronised first
module rnp_reset_nmi_ctrl #(
    parameter int RST_SEQ_CYC = rnp_pkg::RST_SEQ_CYC_DEF
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic osc_running_in,
    input wire logic reset_in_pin_in,
    output logic reset_in_pin_out,
    output logic reset_in_pin_oe_out,
    input wire logic nmi_pin_in,
    input wire logic sw_reset_req_in,
    input wire logic watchdog_timer_reset_req_in,
    input wire logic end_of_init_instr_in,
    input wire logic power_down_instr_in,
    input wire logic system_config_reg_wr_in,
    input wire logic bidir_reset_enable_wdata_in,
    output logic bidir_reset_enable_out,
    output logic reset_indication_out,
    output logic internal_reset_out,
    output logic [1:0] reset_source_out,
    output logic nmi_trap_out,
    output logic power_down_out
);

    localparam int SEQ_CNT_W = rnp_pkg::SEQ_CNT_W;
    localparam logic [SEQ_CNT_W-1:0] SEQ_LAST = SEQ_CNT_W'(RST_SEQ_CYC - 1);

    rnp_pin_if pins ();

    rnp_pkg::rnp_state_e state_ff;
    rnp_pkg::rnp_state_e nxt_state;
    logic [SEQ_CNT_W-1:0] seq_cnt_ff;
    logic [SEQ_CNT_W-1:0] nxt_seq_cnt;
    logic [4:0] holdoff_ff;
    logic [4:0] nxt_holdoff;
    logic bidir_en_ff;
    logic nxt_bidir_en;
    logic bidir_act_ff;
    logic nxt_bidir_act;
    logic ind_ff;
    logic nxt_ind;
    logic [1:0] src_ff;
    logic [1:0] nxt_src;
    logic drive_ff;
    logic nxt_drive;
    logic trap_ff;
    logic pd_ff;
    logic nxt_pd;

    // ==============================================================
    // Pin conditioning
    // ==============================================================
    rnp_pin_filter u_filter (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .reset_pin_in(reset_in_pin_in),
        .nmi_pin_in(nmi_pin_in),
        .pins(pins.filt)
    );

    // ==============================================================
    // Reset request decode
    // ==============================================================
    wire seq_active = (state_ff == rnp_pkg::RNP_ST_SEQ);
    // Own drive echoes back through the filter, so the pin is ignored
    // for a short holdoff after release to avoid a reset loop.
    wire hw_req = pins.rst_low && osc_running_in && (holdoff_ff == 5'h00); // [R1]
    wire any_req = hw_req || sw_reset_req_in || watchdog_timer_reset_req_in;
    wire seq_done = (seq_cnt_ff == SEQ_LAST);
    // Without bidirectional mode a held pin extends the sequence;
    // with it the sequence always runs its full length.
    wire seq_end = seq_done && (bidir_act_ff || !pins.rst_low); // [R15]
    wire init_done = (state_ff == rnp_pkg::RNP_ST_INIT) && end_of_init_instr_in;
    wire cfg_wr_ok = system_config_reg_wr_in && !seq_active &&
                     (state_ff == rnp_pkg::RNP_ST_INIT); // [R14]

    // Reason code; hardware requests win over software ones
    wire [1:0] req_src = hw_req ? rnp_pkg::RSRC_HW_SHORT :
                         watchdog_timer_reset_req_in ? rnp_pkg::RSRC_WDOG :
                         rnp_pkg::RSRC_SW;

    // ==============================================================
    // Sequencer next state
    // ==============================================================
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            rnp_pkg::RNP_ST_SEQ: begin
                if (seq_end) begin
                    nxt_state = rnp_pkg::RNP_ST_INIT;
                end
            end
            rnp_pkg::RNP_ST_INIT: begin
                if (any_req) begin
                    nxt_state = rnp_pkg::RNP_ST_SEQ;
                end else if (end_of_init_instr_in) begin
                    nxt_state = rnp_pkg::RNP_ST_RUN; // [R9]
                end
            end
            rnp_pkg::RNP_ST_RUN: begin
                if (any_req) begin
                    nxt_state = rnp_pkg::RNP_ST_SEQ;
                end
            end
            default: begin
                nxt_state = rnp_pkg::RNP_ST_SEQ;
            end
        endcase
    end

    // Sequence counter starts from zero on each request taken outside a sequence
    assign nxt_seq_cnt = !seq_active ? {SEQ_CNT_W{1'b0}} :
                         seq_done ? seq_cnt_ff : seq_cnt_ff + SEQ_CNT_W'(1);

    assign nxt_holdoff = (seq_active && seq_end) ? rnp_pkg::HOLDOFF_LEN :
                         (holdoff_ff != 5'h00) ? holdoff_ff - 5'h01 : 5'h00;

    // ==============================================================
    // Bidirectional enable and its snapshot for the sequence
    // ==============================================================
    // The snapshot keeps the drive alive although the enable itself
    // clears at the end of the sequence it caused.
    assign nxt_bidir_en = (seq_active && seq_end) ? 1'b0 :        // [R14]
                          cfg_wr_ok ? bidir_reset_enable_wdata_in : bidir_en_ff; // [R6]
    assign nxt_bidir_act = (!seq_active && any_req) ? bidir_en_ff :
                           (seq_active && seq_end) ? 1'b0 : bidir_act_ff; // [R6]

    // Pin driven low for the whole sequence in bidirectional mode
    assign nxt_drive = (!seq_active && any_req) ? bidir_en_ff :
                       (seq_active && !seq_end) ? bidir_act_ff : 1'b0; // [R5]

    // ==============================================================
    // Indication and reason flags
    // ==============================================================
    assign nxt_ind = any_req ? 1'b0 :        // [R8]
                     init_done ? 1'b1 : ind_ff; // [R9]

    wire [1:0] seq_end_src = (src_ff == rnp_pkg::RSRC_HW_SHORT && pins.rst_low) ?
                             rnp_pkg::RSRC_HW_LONG : src_ff;
    assign nxt_src = (!seq_active && any_req) ?
                         (bidir_en_ff ? rnp_pkg::RSRC_HW_LONG : req_src) :   // [R16]
                     (seq_active && seq_end) ?
                         (bidir_act_ff ? rnp_pkg::RSRC_HW_LONG : seq_end_src) : src_ff; // [R16]

    // ==============================================================
    // Power-down gate; only a reset leaves power-down
    // ==============================================================
    wire pd_take = power_down_instr_in && !pins.nmi_level && !seq_active; // [R11]
    assign nxt_pd = seq_active ? 1'b0 :
                    any_req ? 1'b0 :
                    pd_take ? 1'b1 : pd_ff; // [R12]

    // ==============================================================
    // State registers
    // ==============================================================
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= rnp_pkg::RNP_ST_SEQ;
            seq_cnt_ff <= {SEQ_CNT_W{1'b0}};
            holdoff_ff <= 5'h00;
            bidir_en_ff <= 1'b0;
            bidir_act_ff <= 1'b0;
            drive_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            seq_cnt_ff <= nxt_seq_cnt;
            holdoff_ff <= nxt_holdoff;
            bidir_en_ff <= nxt_bidir_en;
            bidir_act_ff <= nxt_bidir_act;
            drive_ff <= nxt_drive;
        end
    end

    // Output flags; power-on counts as a long hardware reset
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ind_ff <= 1'b0;
            src_ff <= rnp_pkg::RSRC_HW_LONG;
            trap_ff <= 1'b0;
            pd_ff <= 1'b0;
        end else begin
            ind_ff <= nxt_ind;
            src_ff <= nxt_src;
            trap_ff <= pins.nmi_fall && !seq_active; // [R10]
            pd_ff <= nxt_pd;
        end
    end

    // ==============================================================
    // Outputs
    // ==============================================================
    assign reset_in_pin_out = 1'b0;       // Open drain: only ever pulls low
    assign reset_in_pin_oe_out = drive_ff; // [R5]
    assign bidir_reset_enable_out = bidir_en_ff;
    assign reset_indication_out = ind_ff;
    assign internal_reset_out = seq_active; // [R1]
    assign reset_source_out = src_ff;
    assign nmi_trap_out = trap_ff;
    assign power_down_out = pd_ff;

endmodule : rnp_reset_nmi_ctrl

// File: verif/rnp_reset_nmi_props.sv
`timescale 1ns/1ps
// ==================================================================
// Checker on the reset and trap pin controller ports
// ==================================================================
module rnp_reset_nmi_props #(
    parameter int RST_SEQ_CYC = 16
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic osc_running_in,
    input wire logic reset_in_pin_in,
    input wire logic reset_in_pin_out,
    input wire logic reset_in_pin_oe_out,
    input wire logic nmi_pin_in,
    input wire logic sw_reset_req_in,
    input wire logic watchdog_timer_reset_req_in,
    input wire logic end_of_init_instr_in,
    input wire logic power_down_instr_in,
    input wire logic reset_indication_out,
    input wire logic internal_reset_out,
    input wire logic [1:0] reset_source_out,
    input wire logic nmi_trap_out,
    input wire logic power_down_out
);
    logic [2:0] lo_cnt_ff;
    logic lo_ok_ff;
    logic [1:0] nmi_hi_ff;
    logic irst_q_ff;

    // Run lengths of raw pin levels; a short spike never arms lo_ok_ff
    // The cycle after a sequence is skipped so the device's own drive cannot arm it
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lo_cnt_ff <= 3'h0;
            lo_ok_ff <= 1'b0;
            nmi_hi_ff <= 2'h0;
            irst_q_ff <= 1'b1;
        end else begin
            irst_q_ff <= internal_reset_out;
            lo_cnt_ff <= reset_in_pin_in ? 3'h0 : lo_cnt_ff + 3'(lo_cnt_ff != 3'h7);
            lo_ok_ff <= !internal_reset_out && !irst_q_ff && (lo_ok_ff || lo_cnt_ff >= 3'h3);
            nmi_hi_ff <= nmi_pin_in ? nmi_hi_ff + 2'(nmi_hi_ff != 2'h3) : 2'h0;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // ==============================================================
    // Properties
    // ==============================================================
    property p_spike; $rose(internal_reset_out) |-> lo_ok_ff || $past(sw_reset_req_in)
        || $past(watchdog_timer_reset_req_in); endproperty
    a_spike: assert property (p_spike) else $error("reset began without a long low");
    // Pin still low now, so a finished sequence cannot count as the answer
    property p_pass; !reset_in_pin_in && lo_cnt_ff == 3'h7 && osc_running_in
        |-> ##[0:24] internal_reset_out; endproperty
    a_pass: assert property (p_pass) else $error("long low pin gave no reset");
    property p_oe; reset_in_pin_oe_out |-> internal_reset_out && !reset_in_pin_out; endproperty
    a_oe: assert property (p_oe) else $error("pin driven outside a sequence");
    property p_ind_low; internal_reset_out |-> !reset_indication_out; endproperty
    a_ind_low: assert property (p_ind_low) else $error("indication high in reset");
    property p_ind_rise; $rose(reset_indication_out) |-> $past(end_of_init_instr_in); endproperty
    a_ind_rise: assert property (p_ind_rise) else $error("indication rose early");
    property p_stretch; $rose(reset_in_pin_oe_out) |-> reset_in_pin_oe_out [*8]; endproperty
    a_stretch: assert property (p_stretch) else $error("pin drive cut short");
    property p_long; $fell(reset_in_pin_oe_out)
        |-> ##[0:1] reset_source_out == rnp_pkg::RSRC_HW_LONG; endproperty
    a_long: assert property (p_long) else $error("wrong reason after driven reset");
    property p_trap; nmi_trap_out |-> !$past(nmi_pin_in, 2) ##1 !nmi_trap_out; endproperty
    a_trap: assert property (p_trap) else $error("trap without fall or too long");
    property p_pd_on; $rose(power_down_out)
        |-> $past(power_down_instr_in) && !$past(nmi_pin_in, 3); endproperty
    a_pd_on: assert property (p_pd_on) else $error("power-down without cause");
    property p_pd_off; power_down_instr_in && nmi_hi_ff == 2'h3 && !power_down_out
        |=> !power_down_out; endproperty
    a_pd_off: assert property (p_pd_off) else $error("power-down taken with pin high");

    c_bidir: cover property ($rose(reset_in_pin_oe_out));
    c_trap: cover property (nmi_trap_out);
    c_pd: cover property ($rose(power_down_out));
endmodule : rnp_reset_nmi_props

bind rnp_reset_nmi_ctrl rnp_reset_nmi_props #(.RST_SEQ_CYC(RST_SEQ_CYC)) i_props (.*);

// File: verif/rnp_ext_model.sv
`timescale 1ns/1ps
// ==================================================================
// External reset circuit and trap source
// ==================================================================
module rnp_ext_model (
    input wire logic ext_low_in,
    input wire logic dev_oe_in,
    input wire logic dev_data_in,
    input wire logic nmi_low_in,
    output logic reset_pin_out,
    output logic nmi_pin_out
);
    // Open-drain wire with pull-up; hold time is set by the bench
    assign reset_pin_out = (dev_oe_in ? dev_data_in : 1'b1) && !ext_low_in;
    // Idle source leaves the trap pin pulled high
    assign nmi_pin_out = !nmi_low_in;
endmodule : rnp_ext_model

// File: verif/rnp_reset_nmi_ctrl_tb.sv
`timescale 1ns/1ps
// ==================================================================
// Self-checking bench for the reset and trap pin controller
// ==================================================================
module rnp_reset_nmi_ctrl_tb;
    localparam int SEQ = 16;
    logic clk = 1'b0;
    logic rst, osc, ext_low, nmi_low, sw, wdt, eoi, pd, cfg_wr, cfg_d;
    logic pin, nmi_pin, pin_d, pin_oe, en, ind, irst, trap, pdn;
    logic [1:0] src;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    rnp_reset_nmi_ctrl #(.RST_SEQ_CYC(SEQ)) i_dut (.sys_clk_in(clk), .rst_in(rst),
        .osc_running_in(osc), .reset_in_pin_in(pin), .reset_in_pin_out(pin_d),
        .reset_in_pin_oe_out(pin_oe), .nmi_pin_in(nmi_pin), .sw_reset_req_in(sw),
        .watchdog_timer_reset_req_in(wdt), .end_of_init_instr_in(eoi),
        .power_down_instr_in(pd), .system_config_reg_wr_in(cfg_wr),
        .bidir_reset_enable_wdata_in(cfg_d), .bidir_reset_enable_out(en),
        .reset_indication_out(ind), .internal_reset_out(irst), .reset_source_out(src),
        .nmi_trap_out(trap), .power_down_out(pdn));
    rnp_ext_model i_ext (.ext_low_in(ext_low), .dev_oe_in(pin_oe), .dev_data_in(pin_d),
        .nmi_low_in(nmi_low), .reset_pin_out(pin), .nmi_pin_out(nmi_pin));

    // ==============================================================
    // Helpers
    // ==============================================================
    task automatic chk(input logic [1:0] seen, input logic [1:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : chk

    // Inputs always move 1 ns after the edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse

    // Bounded wait for the sequence to finish, then the pin holdoff
    task automatic wait_end();
        int n;
        n = 0;
        while (irst !== 1'b0 && n < 300) begin
            tick(1);
            n++;
        end
        chk(2'(irst), 2'h0, "sequence did not end");
        tick(8);
    endtask : wait_end

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // ==============================================================
    // Scenarios
    // ==============================================================
    task automatic t_bidir();
        cfg_d = 1'b1;
        pulse(cfg_wr);
        chk(2'(en), 2'h1, "enable not set");
        pulse(eoi);
        chk(2'(ind), 2'h1, "indication not released");
        cfg_d = 1'b0;
        pulse(cfg_wr);
        chk(2'(en), 2'h1, "enable changed after init");
        // Short pin pulse that still passes the filter
        ext_low = 1'b1;
        tick(3);
        ext_low = 1'b0;
        tick(6);
        chk(2'(pin_oe), 2'h1, "pin not driven");
        chk(2'(ind), 2'h0, "indication high in reset");
        wait_end();
        chk(src, rnp_pkg::RSRC_HW_LONG, "reason not long hardware");
        chk(2'(en), 2'h0, "enable not cleared");
    endtask : t_bidir

    task automatic t_kinds();
        for (int i = 0; i < 2; i++) begin
            if (i == 0) pulse(sw);
            else pulse(wdt);
            chk(2'(irst), 2'h1, "request ignored");
            chk(2'(ind), 2'h0, "indication high");
            wait_end();
            chk(src, i == 0 ? rnp_pkg::RSRC_SW : rnp_pkg::RSRC_WDOG, "reason");
            chk(2'(ind), 2'h0, "indication before init");
        end
        pulse(eoi);
    endtask : t_kinds

    task automatic t_pin();
        ext_low = 1'b1;
        tick(2);
        ext_low = 1'b0;
        tick(10);
        chk(2'(irst), 2'h0, "spike caused reset");
        osc = 1'b0;
        ext_low = 1'b1;
        tick(30);
        chk(2'(irst), 2'h0, "reset without oscillator");
        ext_low = 1'b0;
        tick(10);
        osc = 1'b1;
        ext_low = 1'b1;
        tick(26);
        chk(2'(irst), 2'h1, "long low not taken");
        ext_low = 1'b0;
        wait_end();
        pulse(eoi);
    endtask : t_pin

    task automatic t_nmi();
        pulse(pd);
        chk(2'(pdn), 2'h0, "power-down with pin high");
        nmi_low = 1'b1;
        // Two sync stages plus the edge flop put the pulse at the third edge
        tick(3);
        chk(2'(trap), 2'h1, "no trap on falling pin");
        tick(1);
        chk(2'(trap), 2'h0, "trap pulse too long");
        tick(2);
        chk(2'(trap), 2'h0, "trap repeated on low pin");
        pulse(pd);
        chk(2'(pdn), 2'h1, "power-down refused");
    endtask : t_nmi

    initial begin
        forever #2 clk = ~clk;
    end

    // Run ceiling well above the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        {osc, rst} = 2'b11;
        {ext_low, nmi_low, sw, wdt, eoi, pd, cfg_wr, cfg_d} = 8'h00;
        tick(5);
        rst = 1'b0;
        wait_end();
        chk(2'(ind), 2'h0, "indication after power-on");
        t_bidir();
        t_kinds();
        t_pin();
        t_nmi();
        wrap_up();
    end
endmodule : rnp_reset_nmi_ctrl_tb
